// *** cmt_pkg.sv ***
package cmt_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [7:0] CH1_LOW_IDX = 8'h82;
  localparam logic [7:0] CH1_HIGH_IDX = 8'h83;
  localparam logic [7:0] CH2_LOW_IDX = 8'h84;
  localparam logic [7:0] CH2_HIGH_IDX = 8'h85;
  localparam logic [7:0] CH3_LOW_IDX = 8'h86;
  localparam logic [7:0] CH3_HIGH_IDX = 8'h87;
  localparam logic [7:0] CH4_LOW_IDX = 8'h88;
  localparam logic [7:0] CH4_HIGH_IDX = 8'h89;
  // entry count and channel count
  localparam int NUM_REGS = 8;
  localparam int NUM_CHANS = 4;
  // field position and reset value of every entry
  localparam int FIELD_MSB = 7;
  localparam int FIELD_LSB = 0;
  localparam logic [7:0] RESET_VAL = 8'hff;
  // ahb encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;
endpackage

// *** cmt_min_tracker.sv ***
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/10ps
// Function
// RULE_01 - keep lowest code per channel, bits 7-0
// RULE_02 - read returns value, then reloads 0xFF
// RULE_03 - reset leaves every entry all ones
// RULE_04 - low byte even, high byte odd address
// RULE_05 - replace only on strictly lower code
module cmt_min_tracker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic conv_valid,
  input wire logic [1:0] conv_chan,
  input wire logic [15:0] conv_code
);

  // overview of the storage:
  // - eight byte entries, two per channel, low byte first
  // - entry index is the word index less the channel 1 low index
  // - even entry is the low byte, odd entry the high byte
  // - channel n (0 based) owns entries 2n and 2n+1
  // - each entry comes out of reset as all ones
  // - a read of an entry reloads only that entry
  // - the partner byte of the pair keeps its value on that read
  // - a conversion replaces both bytes of its pair together
  // - the compare is on the whole 16-bit pair, not per byte
  // why compare on the pair:
  // - a per-byte minimum could mix halves of two different codes
  // - the pair then holds one real code, or all ones, until one byte of it is read
  // limitation:
  // - after a read of one byte the pair is half reloaded
  // - the next compare sees that half-reloaded pair as the bound
  // - software should read the low byte, then the high byte, back to back
  // trade-off:
  // - flip-flop storage, eight bytes, no memory macro needed
  // - all entries compare in parallel, no arbitration cycles
  // held minimum bytes, entry 0 is channel 1 low byte
  logic [7:0] min_q [cmt_pkg::NUM_REGS];
  logic [7:0] min_d [cmt_pkg::NUM_REGS];
  // read data register for the data phase
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  // bases after any reload, and per-channel compare results
  logic [7:0] base [cmt_pkg::NUM_REGS];
  logic [cmt_pkg::NUM_CHANS-1:0] lower;
  // address decode
  logic [7:0] word_idx;
  logic hit;
  logic [2:0] entry;
  logic rd_take;
  logic wr_take;

  // bus side notes:
  // - the slave never stretches a transfer, so hreadyout is constant
  // - there is no error case, so hresp is constant okay
  // - read data is registered and stands until the next read is taken
  // - writes are taken and then dropped, the entries are read only
  // - hsize is not decoded, only whole words are expected
  // zero wait state slave, always okay
  assign hreadyout = 1'b1;
  assign hresp = cmt_pkg::HRESP_OKAY;
  assign hrdata = rdata_q;

  // word index from byte address; only aligned words decode
  assign word_idx = haddr[9:2];
  always_comb begin
    // only the eight printed indices hit
    hit = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0) &&
          (word_idx >= cmt_pkg::CH1_LOW_IDX) && (word_idx <= cmt_pkg::CH4_HIGH_IDX);
    entry = 3'(word_idx - cmt_pkg::CH1_LOW_IDX); // RULE_04
  end

  // a transfer is taken on the address phase; hsize is not checked, word only
  assign rd_take = hsel && hready && htrans[1] && !hwrite && hit;
  assign wr_take = hsel && hready && htrans[1] && hwrite;

  // per-entry next value, in this order of priority:
  // - a lower conversion for this channel wins
  // - else a read of this entry reloads all ones
  // - else the entry keeps its value
  // the reload comes first into base, so that a conversion arriving
  // on the same edge as the read is compared with the read byte as all ones
  // and is not lost; the read still returns the old value
  genvar gi;
  generate
    for (gi = 0; gi < cmt_pkg::NUM_REGS; gi++) begin : g_entry
      // reload first, so a conversion in the same cycle still lands
      always_comb begin
        if (rd_take && (entry == 3'(gi))) begin
          base[gi] = cmt_pkg::RESET_VAL; // RULE_02
        end else begin
          base[gi] = min_q[gi];
        end
      end
      // take the matching byte when this channel saw a lower code
      always_comb begin
        if (conv_valid && (conv_chan == 2'(gi / 2)) && lower[gi / 2]) begin
          min_d[gi] = (gi % 2 == 1) ? conv_code[15:8] : conv_code[7:0]; // RULE_05
        end else begin
          min_d[gi] = base[gi];
        end
      end
      // storage; writes never reach it, the entries are read only
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          min_q[gi] <= cmt_pkg::RESET_VAL; // RULE_03
        end else begin
          min_q[gi] <= min_d[gi]; // RULE_01
        end
      end
    end
    for (gi = 0; gi < cmt_pkg::NUM_CHANS; gi++) begin : g_chan
      // strictly lower against the reloaded 16-bit pair
      assign lower[gi] = conv_code < {base[2*gi+1], base[2*gi]}; // RULE_05
    end
  endgenerate

  // read path notes:
  // - the value is taken from min_q, before any reload of this edge
  // - unmapped or misaligned reads answer zero and clear nothing
  // - the register holds when no read is taken, so the data phase
  //   can be sampled at any later edge before the next read
  // read data captured with the old value at the taking edge
  always_comb begin
    rdata_d = rdata_q;
    if (hsel && hready && htrans[1] && !hwrite) begin
      // unmapped reads answer zero
      rdata_d = hit ? {24'h0, min_q[entry][cmt_pkg::FIELD_MSB:cmt_pkg::FIELD_LSB]} : 32'h0;
    end
  end

  // read data register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // helper logic for the checks below
  logic started_q;
  logic [63:0] min_flat;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      started_q <= 1'b0;
    end else begin
      started_q <= 1'b1;
    end
  end
  always_comb begin
    for (int i = 0; i < cmt_pkg::NUM_REGS; i++) begin
      min_flat[8*i +: 8] = min_q[i];
    end
  end
  logic [15:0] held_sel;
  assign held_sel = {min_q[{conv_chan, 1'b1}], min_q[{conv_chan, 1'b0}]};

  a_reset_ones: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_03
    !started_q |-> min_flat == {8{cmt_pkg::RESET_VAL}})
    else $error("entries not all ones after reset");

  a_read_reload: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_02
    rd_take && !conv_valid |=> min_q[$past(entry)] == cmt_pkg::RESET_VAL)
    else $error("read did not reload entry");

  a_read_value: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_01
    rd_take |=> hrdata == {24'h0, $past(min_q[entry])})
    else $error("read data not the held value");

  a_high_map: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_04
    rd_take && word_idx == cmt_pkg::CH4_HIGH_IDX |=> hrdata[7:0] == $past(min_q[7]))
    else $error("odd index not the high byte");

  a_write_ignored: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_02
    wr_take && !conv_valid |=> $stable(min_flat))
    else $error("write changed an entry");

  a_lower_taken: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_05
    conv_valid && !rd_take && conv_code < held_sel
    |=> {min_q[{$past(conv_chan), 1'b1}], min_q[{$past(conv_chan), 1'b0}]} == $past(conv_code))
    else $error("lower code not taken");

  a_not_lower_kept: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_05
    conv_valid && !rd_take && !wr_take && conv_code >= held_sel |=> $stable(min_flat))
    else $error("entry changed without a lower code");

  a_okay_resp: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_take |=> hreadyout && hresp == cmt_pkg::HRESP_OKAY)
    else $error("response not okay");

  // even index maps to the low byte of the pair
  a_low_map: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_04
    rd_take && word_idx == cmt_pkg::CH1_LOW_IDX |=> hrdata[7:0] == $past(min_q[0]))
    else $error("even index not the low byte");

  // reads outside the table return zero
  a_unmapped_zero: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_01
    hsel && hready && htrans[1] && !hwrite && !hit |=> hrdata == 32'h0)
    else $error("unmapped read not zero");

  // read data stands while no read is taken
  a_rdata_hold: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_01
    !(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without a read");

endmodule

// *** tb_channel_minimum_tracker.sv ***
`timescale 1ns/10ps
module tb_channel_minimum_tracker;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, conv_valid = 0;
  logic [31:0] haddr = '0, hwdata = '0, d, r;
  logic [1:0] htrans = '0, conv_chan = '0;
  logic [15:0] conv_code = '0;
  logic [15:0] m [4]; // expected pair per channel
  wire logic hready; // slave answer fed back as bus ready
  wire logic hresp;
  wire logic [31:0] hrdata;
  int n_errors = 0, total_checks = 0, seed = 32'h96ff2173;
  always #12.5 hclk = ~hclk;
  // hsize tied: only whole-word transfers are used
  cmt_min_tracker cmt_min_tracker_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .conv_valid(conv_valid), .conv_chan(conv_chan), .conv_code(conv_code));
  // closing report, also reached by a stuck wait
  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  // bounded wait for hready at a rising edge
  task automatic wt;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
      if (k > 20) begin
        n_errors++;
        summarize;
      end
    end while (hready !== 1'b1);
  endtask
  // one single transfer; byte address is four times the index
  task automatic xfer(logic [7:0] idx, logic wr, output logic [31:0] rd);
    hsel <= 1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= cmt_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    wt;
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= $random(seed); // writes must be ignored anyway
    wt;
    rd = hrdata;
    chk("hresp", 32'(cmt_pkg::HRESP_OKAY), 32'(hresp));
  endtask
  // read and compare; model reloads the byte that was read
  task automatic rdchk(logic [7:0] idx);
    int c;
    xfer(idx, 1'b0, d);
    c = (idx - 8'h82) >> 1;
    if (idx < 8'h82 || idx > 8'h89) chk("unmapped", 32'h0, d);
    else if (idx[0]) begin
      chk("high byte", {24'h0, m[c][15:8]}, d);
      m[c][15:8] = 8'hff;
    end else begin
      chk("low byte", {24'h0, m[c][7:0]}, d);
      m[c][7:0] = 8'hff;
    end
  endtask
  // one conversion pulse; strictly lower codes replace the pair
  task automatic conv(logic [1:0] ch, logic [15:0] code);
    conv_valid <= 1;
    conv_chan <= ch;
    conv_code <= code;
    @(posedge hclk);
    conv_valid <= 0;
    if (code < m[ch]) m[ch] = code;
    @(posedge hclk);
  endtask
  initial begin
    for (int i = 0; i < 4; i++) m[i] = 16'hffff;
    repeat (10) @(posedge hclk);
    hresetn <= 1;
    for (int a = 8'h82; a <= 8'h89; a++) rdchk(8'(a));
    $display("test reset done");
    conv(2'h1, 16'h0010);
    conv(2'h1, 16'h0500);
    xfer(8'h84, 1'b1, d);
    rdchk(8'h84);
    rdchk(8'h84);
    rdchk(8'h85);
    rdchk(8'h81);
    rdchk(8'h8a);
    $display("test corners done");
    repeat (300) begin
      r = $random(seed);
      if (r[0]) conv(r[2:1], r[31:16]);
      else if (r[3:1] == 3'h0) xfer(8'h82 + 8'(r[6:4]), 1'b1, d);
      else rdchk(8'h82 + 8'(r[6:4]));
    end
    $display("test random done");
    // second reset in mid run: every entry back to all ones
    hresetn <= 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1;
    for (int i = 0; i < 4; i++) m[i] = 16'hffff;
    for (int a = 8'h82; a <= 8'h89; a++) rdchk(8'(a));
    $display("test mid reset done");
    summarize;
  end
endmodule
